//--- rtl/cmm_pkg.sv
package cmm_pkg;
  // ------------------------------------------------------------
  // program memory map
  // ------------------------------------------------------------
  localparam logic [15:0] PROG_BASE = 16'h0000;
  localparam logic [15:0] PROG_LAST_8K = 16'h1FFF;
  localparam logic [15:0] PROG_LAST_4K = 16'h0FFF;
  localparam logic [15:0] PROG_LAST_2K = 16'h07FF;
  localparam logic [15:0] PROG_FACTORY_BASE = 16'h1E00;
  localparam int PROG_DEPTH = 8192;
  localparam int PROG_AW = 13;

  // ------------------------------------------------------------
  // data memory map
  // ------------------------------------------------------------
  localparam int DATA_DEPTH = 256;
  localparam logic [7:0] LOWER_LAST = 8'h7F;
  localparam logic [7:0] BANK_BASE = 8'h00;
  localparam logic [7:0] BIT_AREA_BASE = 8'h20;
  localparam logic [7:0] STACK_TOP_OFFSET = 8'h81;
  localparam logic [7:0] STATUS_OFFSET = 8'hD0;
  localparam logic [7:0] STACK_TOP_RESET = 8'h07;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam int BANK_LOW_POS = 3;
  localparam int BANK_HIGH_POS = 4;
  localparam int PARITY_POS = 0;
  localparam logic [2:0] SPC_BIT_LOW3 = 3'h0;

  // ------------------------------------------------------------
  // variant, access kinds and answer state
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    CMM_VAR_8K = 2'h0,
    CMM_VAR_4K = 2'h1,
    CMM_VAR_2K = 2'h2
  } cmm_variant_t;

  typedef enum logic [1:0] {
    CMM_MODE_DIRECT = 2'h0,
    CMM_MODE_INDIRECT = 2'h1,
    CMM_MODE_REG = 2'h2,
    CMM_MODE_STACK = 2'h3
  } cmm_mode_t;

  typedef enum logic [1:0] {
    CMM_ST_IDLE = 2'b00,
    CMM_ST_ANSWER = 2'b01
  } cmm_state_t;
endpackage

//--- rtl/cmm_prog_rom.sv
`timescale 1ns/100ps
`default_nettype none
// read-only code store; loaded only through the programming port
module cmm_prog_rom (
  input wire logic clk_sys_in,
  input wire logic srst_in,
  input wire cmm_pkg::cmm_variant_t variant_in,
  input wire logic rd_in,
  input wire logic [15:0] addr_in,
  input wire logic prog_we_in,
  input wire logic [15:0] prog_addr_in,
  input wire logic [7:0] prog_data_in,
  output logic [7:0] data_out,
  output logic hit_out
);
  import cmm_pkg::*;

  logic [7:0] mem_q [PROG_DEPTH];
  logic [7:0] data_q, data_d;
  logic hit_q, hit_d;
  logic [15:0] last;

  // ------------------------------------------------------------
  // decode
  // ------------------------------------------------------------
  always_comb begin
    unique case (variant_in)
      CMM_VAR_4K: last = PROG_LAST_4K;
      CMM_VAR_2K: last = PROG_LAST_2K;
      default: last = PROG_LAST_8K;
    endcase
    hit_d = hit_q;
    data_d = data_q;
    if (rd_in) begin
      hit_d = (addr_in >= PROG_BASE) && (addr_in <= last);
      data_d = hit_d ? mem_q[addr_in[PROG_AW-1:0]] : 8'hFF;
    end
  end

  // no firmware write path exists; only the programming port stores
  always_ff @(posedge clk_sys_in) begin
    if (prog_we_in && (prog_addr_in <= PROG_LAST_8K)) begin
      mem_q[prog_addr_in[PROG_AW-1:0]] <= prog_data_in;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      data_q <= 8'h00;
      hit_q <= 1'b0;
    end else begin
      data_q <= data_d;
      hit_q <= hit_d;
    end
  end

  assign data_out = data_q;
  assign hit_out = hit_q;
endmodule // cmm_prog_rom
`default_nettype wire

//--- rtl/cmm_memory_map.sv
`timescale 1ns/100ps
`default_nettype none
// Overview of operation
// - 64 kB code space, 8192-byte store at 0x0000..0x1FFF in largest variant.
// - code bytes 0x1E00..0x1FFF reserved for factory, flagged on reads.
// - smaller variants hold 4096 or 2048 code bytes.
// - firmware cannot write code; code-byte reads return stored bytes.
// - 256 bytes internal data RAM, separate from code space.
// - lower 128 bytes reachable both directly and indirectly.
// - 0x00..0x1F form four banks of eight registers.
// - one bank active, chosen by status word bits 3 and 4.
// - bank n maps registers to 8*n..8*n+7.
// - indirect address comes from register 0 or 1 of active bank.
// - 0x20..0x2F also form bits 0x00..0x7F, byte*8+bit.
// - bit operand in direct mode selects single-bit access, otherwise byte access.
// - direct access above 0x7F goes to special registers.
// - indirect access above 0x7F goes to upper RAM.
// - stack pointer at 0x81; push writes pointer+1 then increments.
// - reset loads stack pointer with 0x07.
// - stack anywhere in 256 bytes, depth up to 256.
// - special registers at x0/x8 take bit access, others bytes only.
module cmm_memory_map (
  input wire logic clk_sys_in,
  input wire logic srst_in,
  input wire cmm_pkg::cmm_variant_t variant_in,
  input wire logic code_rd_in,
  input wire logic [15:0] code_addr_in,
  input wire logic prog_we_in,
  input wire logic [15:0] prog_addr_in,
  input wire logic [7:0] prog_data_in,
  input wire logic req_in,
  input wire logic we_in,
  input wire cmm_pkg::cmm_mode_t mode_in,
  input wire logic bit_op_in,
  input wire logic [7:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic push_in,
  input wire logic pop_in,
  output logic [7:0] code_data_out,
  output logic code_hit_out,
  output logic code_factory_out,
  output logic [7:0] rdata_out,
  output logic ack_out,
  output logic spc_sel_out,
  output logic [7:0] spc_addr_out,
  output logic spc_we_out,
  output logic [7:0] spc_wdata_out,
  output logic spc_bit_out,
  output logic bad_bit_out,
  output logic [7:0] stack_top_pointer_out,
  output logic [7:0] program_status_word_out,
  output logic [1:0] bank_out
);
  import cmm_pkg::*;

  // ------------------------------------------------------------
  // storage and state
  // ------------------------------------------------------------
  logic [7:0] ram_q [DATA_DEPTH];
  logic [7:0] stk_q, stk_d;
  logic [7:0] stat_q, stat_d;
  cmm_state_t st_q, st_d;
  logic [7:0] rdata_q, rdata_d;
  logic spc_sel_q, spc_sel_d, spc_we_q, spc_we_d, spc_bit_q, spc_bit_d;
  logic [7:0] spc_addr_q, spc_addr_d, spc_wdata_q, spc_wdata_d;
  logic bad_bit_q, bad_bit_d, factory_q, factory_d;

  logic [1:0] bank;
  logic [7:0] ea, byte_addr, cur, wbyte, stk_next;
  logic [2:0] bitpos;
  logic to_spc, ram_we, is_bit, stk_wr;

  assign bank = {stat_q[BANK_HIGH_POS], stat_q[BANK_LOW_POS]};

  // ------------------------------------------------------------
  // address decode
  // ------------------------------------------------------------
  always_comb begin
    ea = addr_in;
    is_bit = bit_op_in && (mode_in == CMM_MODE_DIRECT);
    unique case (mode_in)
      CMM_MODE_REG: ea = BANK_BASE | {3'h0, bank, addr_in[2:0]};
      CMM_MODE_INDIRECT:
        ea = ram_q[{3'h0, bank, 2'h0, addr_in[0]}];
      CMM_MODE_STACK: ea = push_in ? stk_next : stk_q;
      default: ea = addr_in;
    endcase
    byte_addr = ea;
    bitpos = 3'h0;
    if (is_bit) begin
      bitpos = addr_in[2:0];
      if (addr_in <= LOWER_LAST) begin
        byte_addr = BIT_AREA_BASE + {4'h0, addr_in[6:3]};
      end else begin
        // upper bit addresses can only land on x0/x8 registers
        byte_addr = {addr_in[7:3], 3'h0};
      end
    end
    // only direct mode reaches the special space
    to_spc = (mode_in == CMM_MODE_DIRECT) && (byte_addr > LOWER_LAST);
    cur = ram_q[byte_addr];
    wbyte = wdata_in;
    if (is_bit) begin
      wbyte = cur;
      wbyte[bitpos] = wdata_in[0];
    end
    // a push always stores its operand; other stack accesses only read
    stk_wr = (mode_in == CMM_MODE_STACK) && push_in;
    ram_we = req_in && !to_spc
      && (stk_wr || (we_in && (mode_in != CMM_MODE_STACK)));
  end

  // stk_next wraps naturally in 8 bits
  assign stk_next = stk_q + 8'h01;

  // ------------------------------------------------------------
  // registers and answer
  // ------------------------------------------------------------
  always_comb begin
    stk_d = stk_q;
    stat_d = stat_q;
    st_d = CMM_ST_IDLE;
    rdata_d = rdata_q;
    spc_sel_d = 1'b0;
    spc_we_d = 1'b0;
    spc_bit_d = 1'b0;
    spc_addr_d = spc_addr_q;
    spc_wdata_d = spc_wdata_q;
    bad_bit_d = 1'b0;
    factory_d = factory_q;
    if (code_rd_in) begin
      factory_d = (variant_in == CMM_VAR_8K)
        && (code_addr_in >= PROG_FACTORY_BASE)
        && (code_addr_in <= PROG_LAST_8K);
    end
    if (req_in) begin
      st_d = CMM_ST_ANSWER;
      rdata_d = is_bit ? {7'h00, cur[bitpos]} : cur;
      // a bit operand outside direct mode runs as a byte access, flagged
      bad_bit_d = bit_op_in && (mode_in != CMM_MODE_DIRECT);
      if (to_spc) begin
        spc_sel_d = 1'b1;
        spc_we_d = we_in;
        spc_bit_d = is_bit;
        spc_addr_d = byte_addr;
        spc_wdata_d = wdata_in;
        if (byte_addr == STACK_TOP_OFFSET) begin
          rdata_d = stk_q;
          if (we_in) begin
            stk_d = wdata_in;
          end
        end else if (byte_addr == STATUS_OFFSET) begin
          rdata_d = is_bit ? {7'h00, stat_q[bitpos]} : stat_q;
          if (we_in && is_bit) begin
            stat_d[bitpos] = wdata_in[0];
          end else if (we_in) begin
            stat_d = wdata_in;
          end
        end else begin
          rdata_d = 8'h00;
        end
      end
      if (mode_in == CMM_MODE_STACK) begin
        if (push_in) begin
          stk_d = stk_next;
        end else if (pop_in) begin
          stk_d = stk_q - 8'h01;
        end
      end
    end
    // no accumulator in this block, so parity is held at zero
    stat_d[PARITY_POS] = 1'b0;
  end

  always_ff @(posedge clk_sys_in) begin
    if (ram_we) begin
      ram_q[byte_addr] <= wbyte;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      stk_q <= STACK_TOP_RESET;
      stat_q <= STATUS_RESET;
      st_q <= CMM_ST_IDLE;
      rdata_q <= 8'h00;
      spc_sel_q <= 1'b0;
      spc_we_q <= 1'b0;
      spc_bit_q <= 1'b0;
      spc_addr_q <= 8'h00;
      spc_wdata_q <= 8'h00;
      bad_bit_q <= 1'b0;
      factory_q <= 1'b0;
    end else begin
      stk_q <= stk_d;
      stat_q <= stat_d;
      st_q <= st_d;
      rdata_q <= rdata_d;
      spc_sel_q <= spc_sel_d;
      spc_we_q <= spc_we_d;
      spc_bit_q <= spc_bit_d;
      spc_addr_q <= spc_addr_d;
      spc_wdata_q <= spc_wdata_d;
      bad_bit_q <= bad_bit_d;
      factory_q <= factory_d;
    end
  end

  // ------------------------------------------------------------
  // code store
  // ------------------------------------------------------------
  cmm_prog_rom u_rom (
    .clk_sys_in(clk_sys_in),
    .srst_in(srst_in),
    .variant_in(variant_in),
    .rd_in(code_rd_in),
    .addr_in(code_addr_in),
    .prog_we_in(prog_we_in),
    .prog_addr_in(prog_addr_in),
    .prog_data_in(prog_data_in),
    .data_out(code_data_out),
    .hit_out(code_hit_out)
  );

  assign code_factory_out = factory_q;
  assign rdata_out = rdata_q;
  assign ack_out = (st_q == CMM_ST_ANSWER);
  assign spc_sel_out = spc_sel_q;
  assign spc_addr_out = spc_addr_q;
  assign spc_we_out = spc_we_q;
  assign spc_wdata_out = spc_wdata_q;
  assign spc_bit_out = spc_bit_q;
  assign bad_bit_out = bad_bit_q;
  assign stack_top_pointer_out = stk_q;
  assign program_status_word_out = stat_q;
  assign bank_out = bank;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  sequence s_push;
    req_in && mode_in == CMM_MODE_STACK && push_in;
  endsequence

  sequence s_high_bit;
    req_in && mode_in == CMM_MODE_DIRECT && bit_op_in && addr_in[7];
  endsequence

  a_push_increments: assert property (@(posedge clk_sys_in)
    disable iff (srst_in) s_push |=> stk_q == $past(stk_q) + 8'h01)
    else $error("push did not advance stack pointer");

  a_push_stores: assert property (@(posedge clk_sys_in)
    disable iff (srst_in) s_push |=> ram_q[stk_q] == $past(wdata_in))
    else $error("push did not store its operand");

  a_reset_stack: assert property (@(posedge clk_sys_in)
    srst_in |=> stk_q == STACK_TOP_RESET)
    else $error("stack pointer not at reset value after reset");

  a_direct_high_space: assert property (@(posedge clk_sys_in)
    disable iff (srst_in) req_in && mode_in == CMM_MODE_DIRECT
      && !bit_op_in && addr_in[7] |=> spc_sel_out)
    else $error("direct high access missed special space");

  a_direct_low_ram: assert property (@(posedge clk_sys_in)
    disable iff (srst_in) req_in && mode_in == CMM_MODE_DIRECT
      && !bit_op_in && !addr_in[7] |=> !spc_sel_out && ack_out)
    else $error("direct low access left data RAM");

  a_indirect_ram: assert property (@(posedge clk_sys_in)
    disable iff (srst_in) req_in && mode_in == CMM_MODE_INDIRECT
      |=> !spc_sel_out && ack_out)
    else $error("indirect access reached special space");

  a_reg_bank: assert property (@(posedge clk_sys_in)
    disable iff (srst_in) req_in && we_in && mode_in == CMM_MODE_REG
      |=> ram_q[{3'h0, $past(bank), 3'h0} | ($past(addr_in) & 8'h07)]
      == $past(wdata_in))
    else $error("register write missed the active bank");

  a_bank_follows: assert property (@(posedge clk_sys_in)
    disable iff (srst_in) req_in && we_in && !bit_op_in
      && mode_in == CMM_MODE_DIRECT && addr_in == STATUS_OFFSET
      |=> bank_out == 2'($past(wdata_in) >> BANK_LOW_POS))
    else $error("bank does not follow status word write");

  a_bit_refused: assert property (@(posedge clk_sys_in)
    disable iff (srst_in) req_in && bit_op_in && mode_in != CMM_MODE_DIRECT
      |=> bad_bit_out)
    else $error("bit operand outside direct mode not flagged");

  a_high_bit_aligned: assert property (@(posedge clk_sys_in)
    disable iff (srst_in) s_high_bit |=> spc_bit_out
      && spc_addr_out == ($past(addr_in) & 8'hF8))
    else $error("upper bit access not on an x0/x8 register");

  a_factory_region: assert property (@(posedge clk_sys_in)
    disable iff (srst_in) code_rd_in && variant_in == CMM_VAR_8K
      && code_addr_in == PROG_FACTORY_BASE |=> code_factory_out)
    else $error("factory code region not flagged");

  a_pop_wraps: assert property (@(posedge clk_sys_in)
    disable iff (srst_in) req_in && mode_in == CMM_MODE_STACK && !push_in
      && pop_in && stk_q == 8'h00 |=> stk_q == 8'hFF)
    else $error("stack pointer did not wrap");
endmodule // cmm_memory_map
`default_nettype wire

//--- testbench/cmm_sfr_stub.sv
`timescale 1ns/100ps
`default_nettype none
// ------------------------------------------------------------
// peripheral side of the forwarded register space
// ------------------------------------------------------------
// only latches writes; no read path exists on the block
module cmm_spc_stub (
  input wire logic clk_sys_in,
  input wire logic sel_in,
  input wire logic we_in,
  input wire logic [7:0] addr_in,
  input wire logic [7:0] wdata_in,
  output logic [7:0] last_addr_out,
  output logic [7:0] last_data_out
);
  always_ff @(posedge clk_sys_in) begin
    if (sel_in && we_in) begin
      last_addr_out <= addr_in;
      last_data_out <= wdata_in;
    end
  end
endmodule // cmm_spc_stub
`default_nettype wire

//--- testbench/test_core_memory_map_decode.sv
`timescale 1ns/100ps
`default_nettype none
module test_core_memory_map_decode;
  import cmm_pkg::*;
  logic clk_sys_in = 1'b0;
  logic srst_in = 1'b1;
  cmm_variant_t variant_in = CMM_VAR_8K;
  logic code_rd_in = 1'b0;
  logic [15:0] code_addr_in = 16'h0000;
  logic prog_we_in = 1'b0;
  logic [15:0] prog_addr_in = 16'h0000;
  logic [7:0] prog_data_in = 8'h00;
  logic req_in = 1'b0;
  logic we_in = 1'b0;
  cmm_mode_t mode_in = CMM_MODE_DIRECT;
  logic bit_op_in = 1'b0;
  logic [7:0] addr_in = 8'h00;
  logic [7:0] wdata_in = 8'h00;
  logic push_in = 1'b0;
  logic pop_in = 1'b0;
  logic [7:0] code_data_out, rdata_out, spc_addr_out, spc_wdata_out;
  logic code_hit_out, code_factory_out, ack_out, spc_sel_out, spc_we_out;
  logic spc_bit_out, bad_bit_out;
  logic [7:0] stack_top_pointer_out, program_status_word_out;
  logic [1:0] bank_out;
  logic [7:0] stub_addr, stub_data;
  int n_mismatch = 0;
  int check_count = 0;
  int cyc = 0;
  always #12.5 clk_sys_in = ~clk_sys_in;
  cmm_memory_map uut (.clk_sys_in, .srst_in, .variant_in, .code_rd_in,
    .code_addr_in, .prog_we_in, .prog_addr_in, .prog_data_in, .req_in,
    .we_in, .mode_in, .bit_op_in, .addr_in, .wdata_in, .push_in, .pop_in,
    .code_data_out, .code_hit_out, .code_factory_out, .rdata_out, .ack_out,
    .spc_sel_out, .spc_addr_out, .spc_we_out, .spc_wdata_out, .spc_bit_out,
    .bad_bit_out, .stack_top_pointer_out, .program_status_word_out,
    .bank_out);
  cmm_spc_stub stub (.clk_sys_in, .sel_in(spc_sel_out), .we_in(spc_we_out),
    .addr_in(spc_addr_out), .wdata_in(spc_wdata_out),
    .last_addr_out(stub_addr), .last_data_out(stub_data));
  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic chk(input string nm, input logic [7:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // one access; idle cycle between calls keeps req a clean pulse
  task automatic acc(input logic w, input cmm_mode_t m, input logic b,
    input logic [7:0] a, d, input logic ps = 1'b0, pp = 1'b0);
    @(posedge clk_sys_in);
    req_in <= 1'b1;
    we_in <= w;
    mode_in <= m;
    bit_op_in <= b;
    addr_in <= a;
    wdata_in <= d;
    push_in <= ps;
    pop_in <= pp;
    @(posedge clk_sys_in);
    req_in <= 1'b0;
    push_in <= 1'b0;
    pop_in <= 1'b0;
    #1;
    chk("ack", {7'h00, ack_out}, 8'h01);
  endtask
  task automatic rd(input cmm_mode_t m, input logic [7:0] a, exp);
    acc(1'b0, m, 1'b0, a, 8'h00);
    chk("read data", rdata_out, exp);
  endtask
  task automatic pw(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_sys_in);
    prog_we_in <= 1'b1;
    prog_addr_in <= a;
    prog_data_in <= d;
    @(posedge clk_sys_in);
    prog_we_in <= 1'b0;
  endtask
  task automatic cr(input logic [15:0] a, input logic [7:0] exp,
    input logic h, f);
    @(posedge clk_sys_in);
    code_rd_in <= 1'b1;
    code_addr_in <= a;
    @(posedge clk_sys_in);
    code_rd_in <= 1'b0;
    #1;
    chk("code data", code_data_out, exp);
    chk("code hit", {7'h00, code_hit_out}, {7'h00, h});
    chk("factory", {7'h00, code_factory_out}, {7'h00, f});
  endtask
  // ------------------------------------------------------------
  // tests
  // ------------------------------------------------------------
  always @(posedge clk_sys_in) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_mismatch++;
      end_of_test();
    end
  end
  initial begin
    repeat (16) @(posedge clk_sys_in);
    srst_in <= 1'b0;
    #1;
    chk("stack top", stack_top_pointer_out, 8'h07);
    chk("status", program_status_word_out, 8'h00);
    pw(16'h0010, 8'h5A);
    pw(16'h1E00, 8'hC3);
    pw(16'h07FF, 8'h3C);
    cr(16'h0010, 8'h5A, 1'b1, 1'b0);
    cr(16'h1E00, 8'hC3, 1'b1, 1'b1);
    @(posedge clk_sys_in);
    variant_in <= CMM_VAR_4K;
    cr(16'h1000, 8'hFF, 1'b0, 1'b0);
    cr(16'h07FF, 8'h3C, 1'b1, 1'b0);
    @(posedge clk_sys_in);
    variant_in <= CMM_VAR_2K;
    cr(16'h0800, 8'hFF, 1'b0, 1'b0);
    cr(16'h07FF, 8'h3C, 1'b1, 1'b0);
    $display("test code space done");
    acc(1'b1, CMM_MODE_STACK, 1'b0, 8'h00, 8'hA7, 1'b1);
    chk("stack top", stack_top_pointer_out, 8'h08);
    rd(CMM_MODE_DIRECT, 8'h08, 8'hA7);
    acc(1'b0, CMM_MODE_STACK, 1'b0, 8'h00, 8'h00, 1'b0, 1'b1);
    chk("pop data", rdata_out, 8'hA7);
    chk("stack top", stack_top_pointer_out, 8'h07);
    acc(1'b1, CMM_MODE_DIRECT, 1'b0, 8'h81, 8'hFF);
    acc(1'b1, CMM_MODE_STACK, 1'b0, 8'h00, 8'h69, 1'b1);
    chk("stack top", stack_top_pointer_out, 8'h00);
    rd(CMM_MODE_DIRECT, 8'h00, 8'h69);
    $display("test stack done");
    for (int k = 0; k < 4; k++) begin
      acc(1'b1, CMM_MODE_DIRECT, 1'b0, 8'hD0, 8'(k << 3));
      chk("bank", {6'h00, bank_out}, 8'(k));
      acc(1'b1, CMM_MODE_REG, 1'b0, 8'h02, 8'h40 + 8'(k));
      rd(CMM_MODE_DIRECT, 8'(8 * k + 2), 8'h40 + 8'(k));
    end
    $display("test banks done");
    // occupied forwarded address only; reserved ones stay untouched
    acc(1'b1, CMM_MODE_DIRECT, 1'b0, 8'hD0, 8'h00);
    acc(1'b1, CMM_MODE_DIRECT, 1'b0, 8'hE0, 8'h33);
    // the stub latches one edge after the forwarded pulse
    @(posedge clk_sys_in);
    #1;
    chk("fwd addr", stub_addr, 8'hE0);
    chk("fwd data", stub_data, 8'h33);
    acc(1'b1, CMM_MODE_DIRECT, 1'b0, 8'h01, 8'hE0);
    acc(1'b1, CMM_MODE_INDIRECT, 1'b0, 8'h01, 8'h55);
    @(posedge clk_sys_in);
    #1;
    chk("fwd data", stub_data, 8'h33);
    rd(CMM_MODE_INDIRECT, 8'h01, 8'h55);
    acc(1'b1, CMM_MODE_DIRECT, 1'b0, 8'hD0, 8'h10);
    acc(1'b1, CMM_MODE_DIRECT, 1'b0, 8'h10, 8'h30);
    acc(1'b1, CMM_MODE_DIRECT, 1'b0, 8'h30, 8'h9C);
    rd(CMM_MODE_INDIRECT, 8'h00, 8'h9C);
    $display("test indexing done");
    acc(1'b1, CMM_MODE_DIRECT, 1'b0, 8'h22, 8'h00);
    acc(1'b1, CMM_MODE_DIRECT, 1'b1, 8'h13, 8'h01);
    rd(CMM_MODE_DIRECT, 8'h22, 8'h08);
    acc(1'b0, CMM_MODE_DIRECT, 1'b1, 8'h13, 8'h00);
    chk("bit read", rdata_out, 8'h01);
    acc(1'b1, CMM_MODE_DIRECT, 1'b1, 8'hD3, 8'h01);
    chk("bad bit", {7'h00, bad_bit_out}, 8'h00);
    chk("bank", {6'h00, bank_out}, 8'h03);
    acc(1'b1, CMM_MODE_DIRECT, 1'b1, 8'h85, 8'h01);
    chk("fwd bit", {7'h00, spc_bit_out}, 8'h01);
    chk("fwd bit addr", spc_addr_out, 8'h80);
    acc(1'b0, CMM_MODE_REG, 1'b1, 8'h02, 8'h00);
    chk("bad bit", {7'h00, bad_bit_out}, 8'h01);
    chk("reg byte", rdata_out, 8'h43);
    $display("test bits done");
    end_of_test();
  end
endmodule // test_core_memory_map_decode
`default_nettype wire
